// [design/hpp_pkg.sv]
package hpp_pkg;
  // ----------------------------------------
  // direct register select and strobes
  // ----------------------------------------
  localparam logic       SEL_ADDR_STATUS = 1'h0;
  localparam logic       SEL_DATA        = 1'h1;
  // ----------------------------------------
  // indirect address fields
  // ----------------------------------------
  localparam int         ADDR_TARGET_BIT = 15;
  localparam int         ADDR_READ_BIT   = 14;
  localparam logic [15:0] OWN_WR_BASE    = 16'h8ff0;
  localparam logic [15:0] OWN_RD_BASE    = 16'hcff0;
  localparam logic [15:0] OWN_BASE_MASK  = 16'hfff8;
  // ----------------------------------------
  // own indirect register offsets
  // ----------------------------------------
  localparam logic [2:0] OFS_FIFO        = 3'h0;
  localparam logic [2:0] OFS_CONTROL     = 3'h1;
  localparam logic [2:0] OFS_MASK        = 3'h2;
  localparam logic [2:0] OFS_CLEAR       = 3'h3;
  localparam logic [2:0] OFS_THR_LO      = 3'h4;
  localparam logic [2:0] OFS_THR_HI      = 3'h5;
  localparam logic [2:0] OFS_CNT_LO      = 3'h6;
  localparam logic [2:0] OFS_CNT_HI      = 3'h7;
  // ----------------------------------------
  // status bit positions
  // ----------------------------------------
  localparam int         ST_READY        = 0;
  localparam int         ST_LEVEL        = 1;
  localparam int         ST_FAULT        = 2;
  localparam int         ST_CORE         = 3;
  localparam int         ST_SOF          = 4;
  localparam int         ST_EOF          = 5;
  localparam int         ST_IRQ          = 7;
  // ----------------------------------------
  // control fields and reset values
  // ----------------------------------------
  localparam int         CTL_IRQ_POL     = 5;
  localparam int         CTL_DMA_POL     = 4;
  localparam int         CTL_BURST_LO    = 2;
  localparam int         CTL_FLUSH       = 0;
  localparam logic [7:0] CTL_WR_MASK     = 8'h3c;
  localparam logic [7:0] CONTROL_RST     = 8'h00;
  localparam logic [7:0] MASK_RST        = 8'h00;
  localparam logic [7:0] MASK_WR_MASK    = 8'h3f;
  localparam logic [7:0] CLEAR_WR_MASK   = 8'h3c;
  localparam logic [15:0] THR_RST        = 16'h0001;
  localparam logic [15:0] THR_WR_MASK    = 16'h07f1;
  localparam int         THR_FORCE_BIT   = 0;
  localparam int         THR_FIELD_LO    = 4;
  localparam int         THR_FIELD_HI    = 10;
  // ----------------------------------------
  // fifo
  // ----------------------------------------
  localparam int         FIFO_DEPTH      = 2048;
  localparam int         FIFO_WIDTH      = 8;
endpackage

// [design/hpp_fifo.sv]
`timescale 1ns/100ps
module hpp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     flush,
  // fill side
  input  wire logic [WIDTH-1:0]         in_data,
  input  wire logic                     in_valid,
  output      logic                     in_ready,
  // drain side
  output      logic [WIDTH-1:0]         out_data,
  output      logic                     out_valid,
  input  wire logic                     out_ready,
  // level
  output      logic [$clog2(DEPTH):0]   count
);
  localparam int AW = $clog2(DEPTH);

  // refused at elaboration: the pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin
    $error("hpp_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign count     = wr_ptr_r - rd_ptr_r;
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr_r[AW-1:0]];

  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr_r[AW-1:0]] <= in_data;
  end

  // flush wins over push and pop so the frame start always leaves it empty
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else if (flush)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  never_over_a : assert property (@(posedge clk_sys) disable iff (rst) count <= DEPTH)
    else $error("fifo count exceeds depth");
endmodule

// [design/hpp_port.sv]
`timescale 1ns/100ps
// Functional notes
// - chip select low: select and strobe pick address, status, write-data or read-data register
// - multi-byte values little-endian, low byte at lower indirect address
// - address loaded by two byte writes, low first, pointer toggles
// - any status or data read resets the address byte pointer
// - address bit 15 target, bit 14 direction, bits 13:0 register address
// - status bit 7 high when any of status bits 5:1 is set with its mask bit set
// - status bits 4 and 5 set on envelope rise and fall, cleared by clear register
// - status bit 3 set by core event, cleared by clear bit 3
// - fifo emptied at envelope start; discard or overflow sets status bit 2
// - status bit 1 is count at or above threshold; threshold 1 between frames
// - ready clears on address high write for reads, data write for writes
// - own registers at 0x8ff0 write, 0xcff0 read, offsets 0 to 7, no polling
// - fifo read pops oldest byte; empty read repeats last byte; 2048 bytes
// - control bits 5 and 4 set interrupt and dma pin polarity
// - control bits 3:2 select dma burst; 00 disables and floats request pin
// - control bit 0 write one flushes fifo, reads as zero
// - mask bits 5:0 enable same-position status sources; mask bit 0 is stored but gates nothing, so ready never raises bit 7
// - clear register ones in 5:2 clear matching status bits
// - threshold is 1 if bit 0 set, else bits 10:4 times 16
module hpp_port #(
  parameter int DEPTH = hpp_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // host pins
  input  wire logic        chip_select_n,
  input  wire logic        read_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic        register_select,
  input  wire logic [7:0]  host_data_in,
  output      logic [7:0]  host_data_out,
  output      logic        host_data_oe,
  output      logic        interrupt_pin,
  output      logic        dma_request_out,
  output      logic        dma_request_oe,
  // image stream in
  input  wire logic [7:0]  pix_data,
  input  wire logic        pix_valid,
  output      logic        pix_ready,
  input  wire logic        vertical_envelope,
  // core request side
  output      logic        core_req,
  output      logic        core_target_select,
  output      logic        core_read,
  output      logic [13:0] core_addr,
  output      logic [7:0]  core_wdata,
  input  wire logic        core_done,
  input  wire logic [7:0]  core_rdata,
  input  wire logic        core_event_flag
);
  localparam int CW = $clog2(DEPTH) + 1;

  // the largest dma burst must fit, or the request pin could never rise
  if (DEPTH < 32)
  begin
    $error("hpp_port depth below largest burst");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [4:0]  pin_s1_r;
  logic [4:0]  pin_s2_r;
  logic [7:0]  din_s1_r;
  logic [7:0]  din_s2_r;
  logic        rd_prev_r;
  logic        wr_prev_r;
  logic        env_prev_r;

  // ----------------------------------------
  // direct decode
  // ----------------------------------------
  wire        cs_act   = !pin_s2_r[0];
  wire        rd_act   = cs_act && !pin_s2_r[1] && pin_s2_r[2];
  wire        wr_act   = cs_act && !pin_s2_r[2] && pin_s2_r[1];
  wire        rsel     = pin_s2_r[3];
  wire        env_s    = pin_s2_r[4];
  // writes act at strobe release when data is settled; reads act at strobe start
  wire        wr_done  = wr_prev_r && !wr_act && !pin_s2_r[0];
  wire        rd_start = rd_act && !rd_prev_r;
  wire        wr_addr  = wr_done && rsel == hpp_pkg::SEL_ADDR_STATUS;
  wire        wr_data  = wr_done && rsel == hpp_pkg::SEL_DATA;
  wire        rd_stat  = rd_start && rsel == hpp_pkg::SEL_ADDR_STATUS;
  wire        rd_data  = rd_start && rsel == hpp_pkg::SEL_DATA;
  wire        env_rise = env_s && !env_prev_r;
  wire        env_fall = !env_s && env_prev_r;

  // reset to the idle pin levels, so no false envelope edge follows reset
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_r   <= 5'h07;
      pin_s2_r   <= 5'h07;
      din_s1_r   <= 8'h00;
      din_s2_r   <= 8'h00;
      rd_prev_r  <= 1'b0;
      wr_prev_r  <= 1'b0;
      env_prev_r <= 1'b0;
    end
    else
    begin
      pin_s1_r   <= {vertical_envelope, register_select, write_strobe_n, read_strobe_n, chip_select_n};
      pin_s2_r   <= pin_s1_r;
      din_s1_r   <= host_data_in;
      din_s2_r   <= din_s1_r;
      rd_prev_r  <= rd_act;
      wr_prev_r  <= wr_act;
      env_prev_r <= env_s;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] addr_r;
  logic        hi_ptr_r;
  logic [7:0]  rdata_r;
  logic [7:0]  control_r;
  logic [7:0]  mask_r;
  logic [15:0] thr_r;
  logic [5:2]  flags_r;
  logic        ready_r;
  logic        busy_r;

  wire [15:0] addr_nxt  = hi_ptr_r ? {din_s2_r, addr_r[7:0]} : {addr_r[15:8], din_s2_r};
  wire        own_nxt   = (addr_nxt & hpp_pkg::OWN_BASE_MASK) == hpp_pkg::OWN_WR_BASE ||
                          (addr_nxt & hpp_pkg::OWN_BASE_MASK) == hpp_pkg::OWN_RD_BASE;
  wire        own_cur   = (addr_r & hpp_pkg::OWN_BASE_MASK) == hpp_pkg::OWN_WR_BASE ||
                          (addr_r & hpp_pkg::OWN_BASE_MASK) == hpp_pkg::OWN_RD_BASE;
  wire [2:0]  ofs       = addr_r[2:0];
  wire        is_read   = addr_r[hpp_pkg::ADDR_READ_BIT];
  wire        own_wr    = wr_data && own_cur && !is_read;
  wire        own_rd    = rd_data && own_cur && is_read;
  wire        wr_ctl    = own_wr && ofs == hpp_pkg::OFS_CONTROL;
  wire        wr_clr    = own_wr && ofs == hpp_pkg::OFS_CLEAR;
  wire [5:2]  clr_bits  = wr_clr ? din_s2_r[5:2] : 4'h0;
  wire        flush_cmd = wr_ctl && din_s2_r[hpp_pkg::CTL_FLUSH];

  // ----------------------------------------
  // fifo and level
  // ----------------------------------------
  logic [7:0]    f_data;
  logic          f_valid;
  logic          f_in_ready;
  logic [CW-1:0] f_count;
  wire           fifo_pop  = own_rd && ofs == hpp_pkg::OFS_FIFO;
  wire           overflow  = pix_valid && !f_in_ready && env_s;
  wire           discard   = env_rise && f_valid;

  hpp_fifo #(
    .WIDTH (hpp_pkg::FIFO_WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .flush     (env_rise || flush_cmd),
    .in_data   (pix_data),
    .in_valid  (pix_valid),
    .in_ready  (f_in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (fifo_pop),
    .count     (f_count)
  );

  assign pix_ready = f_in_ready;

  wire [15:0] thr_val   = (thr_r[hpp_pkg::THR_FORCE_BIT] || !env_s) ? 16'h0001 :
                          {5'h00, thr_r[hpp_pkg::THR_FIELD_HI:hpp_pkg::THR_FIELD_LO], 4'h0};
  wire [15:0] count16   = 16'(f_count);
  wire        level     = count16 >= thr_val;
  wire [7:0]  status    = {(|({flags_r, level, 1'b0} & mask_r[5:0])), 1'b0, flags_r, level, ready_r};
  wire [1:0]  burst     = control_r[hpp_pkg::CTL_BURST_LO +: 2];
  wire        dma_on    = burst != 2'h0;

  logic [7:0] own_rd_val;
  always_comb
  begin
    case (ofs)
      hpp_pkg::OFS_FIFO:    own_rd_val = f_valid ? f_data : rdata_r;
      hpp_pkg::OFS_CONTROL: own_rd_val = control_r & hpp_pkg::CTL_WR_MASK;
      hpp_pkg::OFS_MASK:    own_rd_val = mask_r;
      hpp_pkg::OFS_THR_LO:  own_rd_val = thr_r[7:0];
      hpp_pkg::OFS_THR_HI:  own_rd_val = thr_r[15:8];
      hpp_pkg::OFS_CNT_LO:  own_rd_val = count16[7:0];
      hpp_pkg::OFS_CNT_HI:  own_rd_val = count16[15:8];
      default:              own_rd_val = 8'h00;
    endcase
  end

  // ----------------------------------------
  // address, data and own registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      addr_r    <= 16'h0000;
      hi_ptr_r  <= 1'b0;
      rdata_r   <= 8'h00;
      control_r <= hpp_pkg::CONTROL_RST;
      mask_r    <= hpp_pkg::MASK_RST;
      thr_r     <= hpp_pkg::THR_RST;
    end
    else
    begin
      if (rd_stat || rd_data)
        hi_ptr_r <= 1'b0;
      else if (wr_addr)
        hi_ptr_r <= !hi_ptr_r;
      if (wr_addr)
        addr_r <= addr_nxt;
      if (own_rd)
        rdata_r <= own_rd_val;
      else if (busy_r && core_done && is_read)
        rdata_r <= core_rdata;
      if (wr_ctl)
        control_r <= din_s2_r & hpp_pkg::CTL_WR_MASK;
      if (own_wr && ofs == hpp_pkg::OFS_MASK)
        mask_r <= din_s2_r & hpp_pkg::MASK_WR_MASK;
      if (own_wr && ofs == hpp_pkg::OFS_THR_LO)
        thr_r[7:0] <= din_s2_r & hpp_pkg::THR_WR_MASK[7:0];
      if (own_wr && ofs == hpp_pkg::OFS_THR_HI)
        thr_r[15:8] <= din_s2_r & hpp_pkg::THR_WR_MASK[15:8];
    end
  end

  // ----------------------------------------
  // sticky flags: a set in the clear cycle wins
  // ----------------------------------------
  wire [5:2] flag_set = {env_fall, env_rise, core_event_flag, discard || overflow};

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      flags_r <= 4'h0;
    else
      flags_r <= (flags_r & ~clr_bits) | flag_set;
  end

  // ----------------------------------------
  // core request handshake
  // ----------------------------------------
  // the request leaves with the address it was raised for, not the one still in the register
  wire [15:0] core_src = wr_addr ? addr_nxt : addr_r;
  wire start_rd = wr_addr && hi_ptr_r && !own_nxt && addr_nxt[hpp_pkg::ADDR_READ_BIT];
  wire start_wr = wr_data && !own_cur && !is_read;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ready_r    <= 1'b1;
      busy_r     <= 1'b0;
      core_req   <= 1'b0;
      core_wdata <= 8'h00;
    end
    else
    begin
      core_req <= start_rd || start_wr;
      if (start_wr)
        core_wdata <= din_s2_r;
      if (start_rd || start_wr)
      begin
        ready_r <= 1'b0;
        busy_r  <= 1'b1;
      end
      else if (busy_r && core_done)
      begin
        ready_r <= 1'b1;
        busy_r  <= 1'b0;
      end
      else if (wr_addr && own_nxt)
        ready_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // pins, all registered
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      host_data_out      <= 8'h00;
      host_data_oe       <= 1'b0;
      interrupt_pin      <= 1'b0;
      dma_request_out    <= 1'b0;
      dma_request_oe     <= 1'b0;
      core_target_select <= 1'b0;
      core_read          <= 1'b0;
      core_addr          <= 14'h0000;
    end
    else
    begin
      host_data_oe       <= rd_act;
      if (rd_start)
        host_data_out    <= rsel ? (own_cur ? own_rd_val : rdata_r) : status;
      interrupt_pin      <= status[hpp_pkg::ST_IRQ] ^ control_r[hpp_pkg::CTL_IRQ_POL];
      dma_request_out    <= (dma_on && level) ^ control_r[hpp_pkg::CTL_DMA_POL];
      dma_request_oe     <= dma_on;
      core_target_select <= core_src[hpp_pkg::ADDR_TARGET_BIT];
      core_read          <= core_src[hpp_pkg::ADDR_READ_BIT];
      core_addr          <= core_src[13:0];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  ptr_reset_a : assert property (@(posedge clk_sys) disable iff (rst) (rd_stat || rd_data) |=> !hi_ptr_r)
    else $error("byte pointer not reset by read");
  sof_set_a : assert property (@(posedge clk_sys) disable iff (rst) env_rise |=> flags_r[hpp_pkg::ST_SOF])
    else $error("start flag missed");
  eof_set_a : assert property (@(posedge clk_sys) disable iff (rst) env_fall |=> flags_r[hpp_pkg::ST_EOF])
    else $error("end flag missed");
  core_flag_a : assert property (@(posedge clk_sys) disable iff (rst) core_event_flag |=> flags_r[hpp_pkg::ST_CORE])
    else $error("core flag missed");
  frame_flush_a : assert property (@(posedge clk_sys) disable iff (rst) env_rise |=> f_count == '0)
    else $error("fifo not emptied at frame start");
  ready_drop_a : assert property (@(posedge clk_sys) disable iff (rst) start_wr |=> !ready_r ##0 core_req)
    else $error("ready not cleared on write");
  dma_float_a : assert property (@(posedge clk_sys) disable iff (rst) burst == 2'h0 |=> !dma_request_oe)
    else $error("dma pin driven while disabled");
  irq_pin_a : assert property (@(posedge clk_sys) disable iff (rst)
    status[hpp_pkg::ST_IRQ] |=> interrupt_pin == !$past(control_r[hpp_pkg::CTL_IRQ_POL]))
    else $error("interrupt pin wrong");
  dma_pin_a : assert property (@(posedge clk_sys) disable iff (rst)
    (dma_on && level) |=> dma_request_out == !$past(control_r[hpp_pkg::CTL_DMA_POL]))
    else $error("dma request pin wrong");
  oe_read_a : assert property (@(posedge clk_sys) disable iff (rst) rd_start |=> host_data_oe)
    else $error("data pins not driven during read");
  read_drop_a : assert property (@(posedge clk_sys) disable iff (rst) start_rd |=> !ready_r ##0 core_req)
    else $error("ready not cleared on read");
  own_ready_a : assert property (@(posedge clk_sys) disable iff (rst) (wr_addr && own_nxt) |=> ready_r)
    else $error("ready dropped for own register");
  ctl_flush_a : assert property (@(posedge clk_sys) disable iff (rst) flush_cmd |=> f_count == '0)
    else $error("fifo flush ignored");
endmodule

// [verification/hpp_host_model.sv]
`timescale 1ns/100ps
// ----
// host model: strobes held 6 cycles low and 8 high, well over the 3-cycle sync need
// ----
module hpp_host_model (
  // clock
  input  wire logic       clk_sys,
  // host pins
  output      logic       chip_select_n,
  output      logic       read_strobe_n,
  output      logic       write_strobe_n,
  output      logic       register_select,
  output      logic [7:0] host_data_in,
  input  wire logic [7:0] host_data_out
);
  initial
  begin
    chip_select_n = 1'h1;
    read_strobe_n = 1'h1;
    write_strobe_n = 1'h1;
    register_select = 1'h0;
    host_data_in = 8'h00;
  end

  // one direct access; read data taken before the strobe rises
  task automatic acc(input logic wr, input logic sel, input logic [7:0] d, output logic [7:0] q);
  begin
    @(posedge clk_sys);
    chip_select_n <= 1'h0;
    register_select <= sel;
    host_data_in <= d;
    if (wr)
      write_strobe_n <= 1'h0;
    else
      read_strobe_n <= 1'h0;
    repeat (6) @(posedge clk_sys);
    q = host_data_out;
    write_strobe_n <= 1'h1;
    read_strobe_n <= 1'h1;
    repeat (5) @(posedge clk_sys);
    chip_select_n <= 1'h1;
    // a released bus must not keep showing the last byte
    host_data_in <= ~d;
    repeat (2) @(posedge clk_sys);
  end
  endtask

  task automatic addr(input logic [15:0] a);
    logic [7:0] q;
  begin
    acc(1'h1, 1'h0, a[7:0], q);
    acc(1'h1, 1'h0, a[15:8], q);
  end
  endtask

  task automatic poll(output logic [7:0] q);
    int         k;
  begin
    k = 0;
    q = 8'h00;
    while (q[0] !== 1'h1 && k < 60)
    begin
      acc(1'h0, 1'h0, 8'h00, q);
      k++;
    end
  end
  endtask

  task automatic own_wr(input logic [2:0] o, input logic [7:0] d);
    logic [7:0] q;
  begin
    addr(hpp_pkg::OWN_WR_BASE | {13'h0, o});
    acc(1'h1, 1'h1, d, q);
  end
  endtask

  task automatic own_rd(input logic [2:0] o, output logic [7:0] q);
  begin
    addr(hpp_pkg::OWN_RD_BASE | {13'h0, o});
    acc(1'h0, 1'h1, 8'h00, q);
  end
  endtask
endmodule

// [verification/hpp_port_tb_top.sv]
`timescale 1ns/100ps
module hpp_port_tb_top;
  // ----
  // signals
  // ----
  localparam int DEPTH = 64;
  logic        clk_sys = 1'h0;
  logic        rst = 1'h1;
  wire logic   chip_select_n, read_strobe_n, write_strobe_n, register_select;
  wire logic [7:0] host_data_in;
  logic [7:0]  host_data_out, core_wdata, q, c_wdata;
  logic        host_data_oe, interrupt_pin, dma_request_out, dma_request_oe, pix_ready;
  logic        core_req, core_target_select, core_read, c_tgt, c_rd;
  logic [13:0] core_addr, c_addr;
  logic [7:0]  pix_data = 8'h00, seq = 8'h00, core_rdata = 8'h00;
  logic        pix_valid = 1'h0, vertical_envelope = 1'h0, core_done = 1'h0, core_event_flag = 1'h0;
  int          c_wait = 0, cycles = 0, fail_count = 0, n_tests = 0;

  always #2 clk_sys = ~clk_sys;

  hpp_port #(.DEPTH(DEPTH)) u_hpp_port (.clk_sys, .rst, .chip_select_n, .read_strobe_n, .write_strobe_n,
    .register_select, .host_data_in, .host_data_out, .host_data_oe, .interrupt_pin, .dma_request_out,
    .dma_request_oe, .pix_data, .pix_valid, .pix_ready, .vertical_envelope, .core_req, .core_target_select,
    .core_read, .core_addr, .core_wdata, .core_done, .core_rdata, .core_event_flag);

  hpp_host_model u_host (.clk_sys, .chip_select_n, .read_strobe_n, .write_strobe_n, .register_select,
    .host_data_in, .host_data_out);

  // ----
  // core responder: slow on purpose so a cleared ready can be seen
  // ----
  always @(posedge clk_sys)
  begin
    core_done <= 1'h0;
    core_rdata <= ~core_rdata;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      results();
    end
    if (core_req === 1'h1)
    begin
      c_addr <= core_addr;
      c_wdata <= core_wdata;
      c_tgt <= core_target_select;
      c_rd <= core_read;
      c_wait <= 40;
    end
    else if (c_wait > 0)
    begin
      c_wait <= c_wait - 1;
      if (c_wait == 1)
      begin
        core_done <= 1'h1;
        core_rdata <= c_addr[7:0] ^ 8'ha5;
      end
    end
  end

  // ----
  // compare and access helpers
  // ----
  task automatic chkv(input logic [15:0] got, input logic [15:0] exp, input string what);
  begin
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  end
  endtask

  task automatic chkb(input logic got, input logic exp, input string what);
  begin
    chkv({15'h0, got}, {15'h0, exp}, what);
  end
  endtask

  task automatic sts(input logic [7:0] e);
  begin
    u_host.acc(1'h0, 1'h0, 8'h00, q);
    chkv({8'h00, q}, {8'h00, e}, "status");
  end
  endtask

  task automatic ork(input logic [2:0] o, input logic [7:0] e);
  begin
    u_host.own_rd(o, q);
    chkv({8'h00, q}, {8'h00, e}, "own reg");
  end
  endtask

  task automatic push(input int n);
  begin
    repeat (n)
    begin
      @(posedge clk_sys);
      pix_data <= seq;
      pix_valid <= 1'h1;
      seq <= seq + 8'h01;
    end
    @(posedge clk_sys);
    pix_valid <= 1'h0;
    pix_data <= ~pix_data;
    repeat (4) @(posedge clk_sys);
  end
  endtask

  task automatic results;
  begin
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask

  // ----
  // sequence
  // ----
  logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'h0;
    repeat (4) @(posedge clk_sys);
    sts(8'h01);
    chkb(dma_request_oe, 1'h0, "dma oe");
    chkb(interrupt_pin, 1'h0, "irq pin");
    chkb(host_data_oe, 1'h0, "oe idle");
    for (int o = 1; o < 8; o++)
      if (o != 3)
        ork(o[2:0], rv[o]);
    u_host.own_wr(hpp_pkg::OFS_CONTROL, 8'hff);
    ork(hpp_pkg::OFS_CONTROL, 8'h3c);
    chkb(dma_request_oe, 1'h1, "dma oe");
    chkb(dma_request_out, 1'h1, "dma pin");
    chkb(interrupt_pin, 1'h1, "irq pin");
    u_host.own_wr(hpp_pkg::OFS_MASK, 8'hff);
    ork(hpp_pkg::OFS_MASK, 8'h3f);
    u_host.own_wr(hpp_pkg::OFS_MASK, 8'h00);
    u_host.own_wr(hpp_pkg::OFS_THR_LO, 8'hff);
    u_host.own_wr(hpp_pkg::OFS_THR_HI, 8'hff);
    ork(hpp_pkg::OFS_THR_LO, 8'hf1);
    ork(hpp_pkg::OFS_THR_HI, 8'h07);
    // threshold of 16 stays above the 8-byte burst
    u_host.own_wr(hpp_pkg::OFS_THR_LO, 8'h10);
    u_host.own_wr(hpp_pkg::OFS_THR_HI, 8'h00);
    u_host.own_wr(hpp_pkg::OFS_CONTROL, 8'h04);
    u_host.addr(16'h0123);
    u_host.acc(1'h1, 1'h1, 8'h5a, q);
    sts(8'h00);
    chkv({c_tgt, c_rd, c_addr}, 16'h0123, "core write");
    chkv({8'h00, c_wdata}, 16'h005a, "core wdata");
    u_host.poll(q);
    chkb(q[0], 1'h1, "ready");
    u_host.addr(16'hc0ab);
    sts(8'h00);
    u_host.poll(q);
    chkb(q[0], 1'h1, "ready");
    u_host.acc(1'h0, 1'h1, 8'h00, q);
    chkv({8'h00, q}, 16'h000e, "read data");
    chkv({c_tgt, c_rd, c_addr}, 16'hc0ab, "core read");
    u_host.acc(1'h1, 1'h0, 8'h77, q);
    sts(8'h01);
    u_host.addr(16'h4011);
    u_host.poll(q);
    chkb(q[0], 1'h1, "ready");
    chkv({c_tgt, c_rd, c_addr}, 16'h4011, "core read");
    vertical_envelope <= 1'h1;
    repeat (8) @(posedge clk_sys);
    sts(8'h11);
    push(15);
    sts(8'h11);
    push(1);
    sts(8'h13);
    chkb(dma_request_out, 1'h1, "dma pin");
    ork(hpp_pkg::OFS_CNT_LO, 8'h10);
    ork(hpp_pkg::OFS_CNT_HI, 8'h00);
    for (int i = 0; i < 16; i++)
      ork(hpp_pkg::OFS_FIFO, i[7:0]);
    ork(hpp_pkg::OFS_FIFO, 8'h0f);
    sts(8'h11);
    chkb(dma_request_out, 1'h0, "dma pin");
    push(DEPTH + 6);
    sts(8'h17);
    chkb(pix_ready, 1'h0, "fifo full");
    u_host.own_wr(hpp_pkg::OFS_CONTROL, 8'h05);
    ork(hpp_pkg::OFS_CNT_LO, 8'h00);
    sts(8'h15);
    chkb(pix_ready, 1'h1, "fifo ready");
    vertical_envelope <= 1'h0;
    repeat (8) @(posedge clk_sys);
    sts(8'h35);
    push(1);
    sts(8'h37);
    u_host.own_wr(hpp_pkg::OFS_CLEAR, 8'h3c);
    sts(8'h03);
    vertical_envelope <= 1'h1;
    repeat (8) @(posedge clk_sys);
    sts(8'h15);
    ork(hpp_pkg::OFS_CNT_LO, 8'h00);
    u_host.own_wr(hpp_pkg::OFS_CLEAR, 8'h10);
    sts(8'h05);
    u_host.own_wr(hpp_pkg::OFS_CLEAR, 8'h04);
    sts(8'h01);
    @(posedge clk_sys);
    core_event_flag <= 1'h1;
    @(posedge clk_sys);
    core_event_flag <= 1'h0;
    repeat (4) @(posedge clk_sys);
    sts(8'h09);
    chkb(interrupt_pin, 1'h0, "irq pin");
    u_host.own_wr(hpp_pkg::OFS_MASK, 8'h08);
    sts(8'h89);
    chkb(interrupt_pin, 1'h1, "irq pin");
    u_host.own_wr(hpp_pkg::OFS_CONTROL, 8'h24);
    chkb(interrupt_pin, 1'h0, "irq pin");
    u_host.own_wr(hpp_pkg::OFS_CLEAR, 8'h08);
    sts(8'h01);
    chkb(interrupt_pin, 1'h1, "irq pin");
    results();
  end
endmodule
